// ### design/acc_defs.svh
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Register byte addresses
`define ACC_ADDR_CTRL0      12'h000
`define ACC_ADDR_CTRL1      12'h004
`define ACC_ADDR_CTRL2      12'h008
`define ACC_ADDR_RESH       12'h00C
`define ACC_ADDR_RESL       12'h010
`define ACC_ADDR_CMPH       12'h014
`define ACC_ADDR_CMPL       12'h018
`define ACC_ADDR_DELAY      12'h01C
`define ACC_ADDR_BRAKE      12'h020

// Control 0 fields
`define ACC_C0_DONE         7
`define ACC_C0_START        6
`define ACC_C0_TSEL_LO      4
`define ACC_C0_CHAN_LO      0
// Control 1 fields
`define ACC_C1_IRQEN        7
`define ACC_C1_SWAP         6
`define ACC_C1_TTYP_LO      2
`define ACC_C1_EXTEN        1
`define ACC_C1_PWREN        0
// Control 2 fields
`define ACC_C2_BRKEN        7
`define ACC_C2_POL          6
`define ACC_C2_CMPEN        5
`define ACC_C2_CMPOUT       4
// Brake register fields
`define ACC_BK_FLAG         0
`define ACC_BK_IEN          1
`define ACC_BK_RISE         2

// Trigger type codes
`define ACC_TT_FALL         2'h0
`define ACC_TT_RISE         2'h1
`define ACC_TT_CENTER       2'h2
`define ACC_TT_END          2'h3

// Channel codes
`define ACC_CH_LAST_PIN     4'h7
`define ACC_CH_BANDGAP      4'h8

// Conversion length: time in ns and derived cycles at 200 MHz
`define ACC_CONV_NS         1000
`define ACC_CLK_MHZ         200
`define ACC_CONV_CYC        ((`ACC_CONV_NS * `ACC_CLK_MHZ) / 1000)

`endif

// ### design/acc_pkg.sv
package acc_pkg;
    typedef enum logic [1:0] {ACC_IDLE, ACC_DELAY, ACC_CONV} acc_state_t;
endpackage

// ### design/acc_sar_core.sv
`timescale 1ns/10ps
`include "acc_defs.svh"
// Successive-approximation sequencer: one bit decided per step
module acc_sar_core (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        go,
    input  wire logic        compHigher,
    output logic [11:0]      trialCode,
    output logic [11:0]      result,
    output logic             busy,
    output logic             done
);
    localparam int STEP = `ACC_CONV_CYC / 12;

    logic [11:0] mask_q;
    logic [11:0] code_q;
    logic [7:0]  tick_q;

    assign trialCode = code_q | mask_q;

    // Bit-by-bit approximation, each bit held STEP cycles for settling
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= 12'h000;
            code_q <= 12'h000;
            tick_q <= 8'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
            result <= 12'h000;
        end else begin
            done <= 1'b0;
            if (go && !busy) begin
                busy   <= 1'b1;
                mask_q <= 12'h800;
                code_q <= 12'h000;
                tick_q <= 8'h00;
            end else if (busy) begin
                if (tick_q == 8'(STEP - 1)) begin
                    tick_q <= 8'h00;
                    if (!compHigher) begin
                        code_q <= code_q | mask_q;   // Keep bit, input is at or above trial
                    end
                    mask_q <= mask_q >> 1;
                    if (mask_q == 12'h001) begin
                        busy   <= 1'b0;
                        done   <= 1'b1;
                        result <= compHigher ? code_q : (code_q | mask_q);
                    end
                end else begin
                    tick_q <= tick_q + 8'h01;
                end
            end
        end
    end
endmodule

// ### design/acc_conv_ctrl.sv
`timescale 1ns/10ps
`include "acc_defs.svh"
// Contract
// RL1 - Software enables converter power before converting; clearing it powers down.
// RL2 - Selected channel is routed to the single sample-and-hold stage.
// RL3 - Writing one to the start bit begins a conversion.
// RL4 - On completion start clears, done flag sets, interrupt requested if enabled.
// RL5 - Result upper eight bits go high register, lower four to low.
// RL6 - Result equals input over reference scaled by 4095.
// RL7 - With external trigger enabled, PWM or pin events start conversion.
// RL8 - Hardware trigger also sets the start bit.
// RL9 - Trigger pin swap selects one of two trigger pins.
// RL10 - Trigger qualified by source select and type select together.
// RL11 - Programmable delay between trigger point and conversion start.
// RL12 - Start requests during a conversion are silently discarded.
// RL13 - Digital comparator checks each result against a 12-bit constant.
// RL14 - Comparison happens at each completion while comparator enabled.
// RL15 - Comparator output bit shows outcome, optionally inverted by polarity.
// RL16 - Compare result drives fault brake only with brake enable set.
// RL17 - Comparator output becoming set makes a compare brake event.
// RL18 - Fault pin or compare event sets brake flag; interrupt if enabled.
// RL19 - Only software clears the brake flag.
// RL20 - No new conversion starts while the done flag is one.
// RL21 - Start bit reads busy state; writing zero has no effect.
// RL22 - Source codes: 00 PWM0, 01 PWM2, 10 PWM4, 11 pin.
// RL23 - Channel codes 0..7 select inputs, 8 selects band-gap; others reserved.
// RL24 - Trigger type encoding and conversion length are fixed here.
module acc_conv_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog front end
    output logic [8:0]       analogSelect,
    output logic             converterPowerEnable,
    output logic [11:0]      dacTrial,
    input  wire logic        compHigher,
    // Trigger sources
    input  wire logic [2:0]  pwmChannel,
    input  wire logic [2:0]  pwmPeriodCenter,
    input  wire logic [2:0]  pwmPeriodEnd,
    input  wire logic        triggerPinA,
    input  wire logic        triggerPinB,
    input  wire logic        faultInputPin,
    // Events
    output logic             conversionIrq,
    output logic             brakeIrq,
    output logic             faultBrake
);
    logic [3:0]  inputChannelSelect_q;
    logic [1:0]  triggerSourceSelect_q;
    logic [1:0]  triggerTypeSelect_q;
    logic        triggerPinSwap_q;
    logic        externalTriggerEnable_q;
    logic        converterPowerEnable_q;
    logic        conversionDoneFlag_q;
    logic        comparatorEnable_q;
    logic        comparatorPolarity_q;
    logic        comparatorOutput_q;
    logic        compareBrakeEnable_q;
    logic        brakeFlag_q;
    logic        brakeInterruptEnable_q;
    logic        convIrqEnable_q;
    logic [7:0]  resultHighByte_q;
    logic [3:0]  resultLowNibble_q;
    logic [7:0]  compareValueHigh_q;
    logic [3:0]  compareValueLow_q;
    logic [7:0]  triggerDelay_q;
    logic [7:0]  delayCnt_q;
    acc_pkg::acc_state_t state_q;

    // Two-flop synchronisers for all pins, then an edge history stage
    logic [11:0] pinMeta_q;
    logic [11:0] pinSync_q;
    logic [11:0] pinPrev_q;
    logic [11:0] pinRaw;
    assign pinRaw = {faultInputPin, triggerPinB, triggerPinA, pwmPeriodEnd, pwmPeriodCenter, pwmChannel};

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pinMeta_q[gi] <= 1'b0;
                    pinSync_q[gi] <= 1'b0;
                    pinPrev_q[gi] <= 1'b0;
                end else begin
                    pinMeta_q[gi] <= pinRaw[gi];
                    pinSync_q[gi] <= pinMeta_q[gi];
                    pinPrev_q[gi] <= pinSync_q[gi];
                end
            end
        end
    endgenerate

    // Bus decode
    logic        wrEn;
    logic        rdEn;
    logic        addrHit;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign addrHit = (paddr == `ACC_ADDR_CTRL0) || (paddr == `ACC_ADDR_CTRL1) ||
                     (paddr == `ACC_ADDR_CTRL2) || (paddr == `ACC_ADDR_RESH) ||
                     (paddr == `ACC_ADDR_RESL) || (paddr == `ACC_ADDR_CMPH) ||
                     (paddr == `ACC_ADDR_CMPL) || (paddr == `ACC_ADDR_DELAY) ||
                     (paddr == `ACC_ADDR_BRAKE);

    // Trigger qualification: source then type
    logic        selLevel;
    logic        selPrev;
    logic        extPinSync;
    logic        extPinPrev;
    logic        trigEvent;
    assign extPinSync = triggerPinSwap_q ? pinSync_q[10] : pinSync_q[9];   // [RL9]
    assign extPinPrev = triggerPinSwap_q ? pinPrev_q[10] : pinPrev_q[9];

    always_comb begin
        selLevel = 1'b0;
        selPrev  = 1'b0;
        unique case (triggerSourceSelect_q)   // [RL22]
            2'h0: begin
                selLevel = pinSync_q[0];
                selPrev  = pinPrev_q[0];
            end
            2'h1: begin
                selLevel = pinSync_q[1];
                selPrev  = pinPrev_q[1];
            end
            2'h2: begin
                selLevel = pinSync_q[2];
                selPrev  = pinPrev_q[2];
            end
            2'h3: begin
                selLevel = extPinSync;
                selPrev  = extPinPrev;
            end
        endcase
    end

    // Period points per PWM channel: center on bits 3..5, end of period on bits 6..8 shifted by source
    logic        pointCenter;
    logic        pointEnd;
    always_comb begin
        pointCenter = 1'b0;
        pointEnd    = 1'b0;
        if (triggerSourceSelect_q != 2'h3) begin
            pointCenter = pinSync_q[3 + triggerSourceSelect_q] && !pinPrev_q[3 + triggerSourceSelect_q];
            pointEnd    = pinSync_q[6 + triggerSourceSelect_q] && !pinPrev_q[6 + triggerSourceSelect_q];
        end
    end
    assign trigEvent = externalTriggerEnable_q && (                              // [RL7]
        ((triggerTypeSelect_q == `ACC_TT_FALL) && !selLevel && selPrev) ||       // [RL10]
        ((triggerTypeSelect_q == `ACC_TT_RISE) && selLevel && !selPrev) ||
        ((triggerTypeSelect_q == `ACC_TT_CENTER) && pointCenter) ||
        ((triggerTypeSelect_q == `ACC_TT_END) && pointEnd));

    // Conversion core
    logic        coreGo;
    logic        coreBusy;
    logic        coreDone;
    logic [11:0] coreResult;
    logic [11:0] coreTrial;
    logic        swStart;
    assign swStart = wrEn && (paddr == `ACC_ADDR_CTRL0) && pwdata[`ACC_C0_START];   // [RL3] [RL21]

    acc_sar_core u_core (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .go         (coreGo),
        .compHigher (compHigher),
        .trialCode  (coreTrial),
        .result     (coreResult),
        .busy       (coreBusy),
        .done       (coreDone)
    );

    // Start sequencing: requests in any state but idle are dropped
    logic        canStart;
    assign canStart = converterPowerEnable_q && !conversionDoneFlag_q;            // [RL20]
    assign coreGo = (state_q == acc_pkg::ACC_CONV) && !coreBusy && !coreDone && (delayCnt_q == 8'h00);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= acc_pkg::ACC_IDLE;
            delayCnt_q <= 8'h00;
        end else begin
            unique case (state_q)
                acc_pkg::ACC_IDLE: begin
                    if (canStart && swStart) begin
                        state_q    <= acc_pkg::ACC_CONV;
                        delayCnt_q <= 8'h00;
                    end else if (canStart && trigEvent) begin
                        state_q    <= acc_pkg::ACC_DELAY;                         // [RL11]
                        delayCnt_q <= triggerDelay_q;
                    end
                end
                acc_pkg::ACC_DELAY: begin
                    if (delayCnt_q == 8'h00) begin
                        state_q <= acc_pkg::ACC_CONV;
                    end else begin
                        delayCnt_q <= delayCnt_q - 8'h01;
                    end
                end
                acc_pkg::ACC_CONV: begin
                    if (coreDone) begin
                        state_q <= acc_pkg::ACC_IDLE;                             // [RL12]
                    end
                end
            endcase
        end
    end

    // Compare against constant at completion
    logic        cmpRaw;
    logic        cmpNext;
    assign cmpRaw  = coreResult >= {compareValueHigh_q, compareValueLow_q};       // [RL13]
    assign cmpNext = cmpRaw ^ comparatorPolarity_q;                               // [RL15]

    // Result, flags, comparator
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            resultHighByte_q     <= 8'h00;
            resultLowNibble_q    <= 4'h0;
            conversionDoneFlag_q <= 1'b0;
            comparatorOutput_q   <= 1'b0;
        end else begin
            if (coreDone) begin
                resultHighByte_q  <= coreResult[11:4];                            // [RL5] [RL6]
                resultLowNibble_q <= coreResult[3:0];
            end
            if (coreDone) begin
                conversionDoneFlag_q <= 1'b1;                                     // [RL4]
            end else if (wrEn && (paddr == `ACC_ADDR_CTRL0) && !pwdata[`ACC_C0_DONE]) begin
                conversionDoneFlag_q <= 1'b0;
            end
            if (coreDone && comparatorEnable_q) begin
                comparatorOutput_q <= cmpNext;                                    // [RL14]
            end
        end
    end

    // Compare event on rising comparator output, fault pin edge with its own polarity
    logic        cmpPrev_q;
    logic        cmpEvent;
    logic        faultEvent;
    logic        faultRising_q;
    assign cmpEvent   = comparatorOutput_q && !cmpPrev_q && compareBrakeEnable_q; // [RL16] [RL17]
    assign faultEvent = faultRising_q ? (pinSync_q[11] && !pinPrev_q[11]) : (!pinSync_q[11] && pinPrev_q[11]);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmpPrev_q   <= 1'b0;
            brakeFlag_q <= 1'b0;
        end else begin
            cmpPrev_q <= comparatorOutput_q;
            if (cmpEvent || faultEvent) begin
                brakeFlag_q <= 1'b1;                                              // [RL18]
            end else if (wrEn && (paddr == `ACC_ADDR_BRAKE) && !pwdata[`ACC_BK_FLAG]) begin
                brakeFlag_q <= 1'b0;                                              // [RL19]
            end
        end
    end

    // Software registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            inputChannelSelect_q    <= 4'h0;
            triggerSourceSelect_q   <= 2'h0;
            triggerTypeSelect_q     <= 2'h0;
            triggerPinSwap_q        <= 1'b0;
            externalTriggerEnable_q <= 1'b0;
            converterPowerEnable_q  <= 1'b0;
            comparatorEnable_q      <= 1'b0;
            comparatorPolarity_q    <= 1'b0;
            compareBrakeEnable_q    <= 1'b0;
            brakeInterruptEnable_q  <= 1'b0;
            convIrqEnable_q         <= 1'b0;
            faultRising_q           <= 1'b0;
            compareValueHigh_q      <= 8'h00;
            compareValueLow_q       <= 4'h0;
            triggerDelay_q          <= 8'h00;
        end else if (wrEn) begin
            unique case (paddr)
                `ACC_ADDR_CTRL0: begin
                    triggerSourceSelect_q <= pwdata[`ACC_C0_TSEL_LO +: 2];
                    inputChannelSelect_q  <= pwdata[`ACC_C0_CHAN_LO +: 4];
                end
                `ACC_ADDR_CTRL1: begin
                    triggerPinSwap_q        <= pwdata[`ACC_C1_SWAP];
                    triggerTypeSelect_q     <= pwdata[`ACC_C1_TTYP_LO +: 2];      // [RL24]
                    externalTriggerEnable_q <= pwdata[`ACC_C1_EXTEN];
                    converterPowerEnable_q  <= pwdata[`ACC_C1_PWREN];             // [RL1]
                    convIrqEnable_q         <= pwdata[`ACC_C1_IRQEN];
                end
                `ACC_ADDR_CTRL2: begin
                    compareBrakeEnable_q <= pwdata[`ACC_C2_BRKEN];
                    comparatorPolarity_q <= pwdata[`ACC_C2_POL];
                    comparatorEnable_q   <= pwdata[`ACC_C2_CMPEN];
                end
                `ACC_ADDR_CMPH:  compareValueHigh_q <= pwdata[7:0];
                `ACC_ADDR_CMPL:  compareValueLow_q  <= pwdata[3:0];
                `ACC_ADDR_DELAY: triggerDelay_q     <= pwdata[7:0];
                `ACC_ADDR_BRAKE: begin
                    brakeInterruptEnable_q <= pwdata[`ACC_BK_IEN];
                    faultRising_q          <= pwdata[`ACC_BK_RISE];
                end
                default: ;
            endcase
        end
    end

    // Read mux and bus answer, registered; zero wait states after setup
    logic        busyBit;
    assign busyBit = (state_q != acc_pkg::ACC_IDLE);                              // [RL8] [RL21]

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addrHit;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `ACC_ADDR_CTRL0: prdata <= {24'h00_0000, conversionDoneFlag_q, busyBit,
                                                triggerSourceSelect_q, inputChannelSelect_q};
                    `ACC_ADDR_CTRL1: prdata <= {24'h00_0000, convIrqEnable_q, triggerPinSwap_q, 2'h0,
                                                triggerTypeSelect_q, externalTriggerEnable_q,
                                                converterPowerEnable_q};
                    `ACC_ADDR_CTRL2: prdata <= {24'h00_0000, compareBrakeEnable_q, comparatorPolarity_q,
                                                comparatorEnable_q, comparatorOutput_q, 4'h0};
                    `ACC_ADDR_RESH:  prdata <= {24'h00_0000, resultHighByte_q};
                    `ACC_ADDR_RESL:  prdata <= {28'h000_0000, resultLowNibble_q};
                    `ACC_ADDR_CMPH:  prdata <= {24'h00_0000, compareValueHigh_q};
                    `ACC_ADDR_CMPL:  prdata <= {28'h000_0000, compareValueLow_q};
                    `ACC_ADDR_DELAY: prdata <= {24'h00_0000, triggerDelay_q};
                    `ACC_ADDR_BRAKE: prdata <= {29'h0000_0000, faultRising_q, brakeInterruptEnable_q,
                                                brakeFlag_q};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Analog side and event outputs, all registered
    logic [8:0]  chanDecode;
    always_comb begin
        chanDecode = 9'h000;
        if (converterPowerEnable_q && inputChannelSelect_q <= `ACC_CH_BANDGAP) begin
            chanDecode[inputChannelSelect_q] = 1'b1;                              // [RL2] [RL23]
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            analogSelect         <= 9'h000;
            converterPowerEnable <= 1'b0;
            dacTrial             <= 12'h000;
            conversionIrq        <= 1'b0;
            brakeIrq             <= 1'b0;
            faultBrake           <= 1'b0;
        end else begin
            analogSelect         <= chanDecode;
            converterPowerEnable <= converterPowerEnable_q;
            dacTrial             <= coreTrial;
            conversionIrq        <= conversionDoneFlag_q && convIrqEnable_q;      // [RL4]
            brakeIrq             <= brakeFlag_q && brakeInterruptEnable_q;        // [RL18]
            faultBrake           <= cmpEvent || faultEvent;                       // [RL17]
        end
    end
endmodule

// ### dv/acc_front_model.sv
`timescale 1ns/10ps
module acc_front_model (
    input  wire logic        sys_clk,
    input  wire logic [8:0]  analogSelect,
    input  wire logic        converterPowerEnable,
    input  wire logic [11:0] dacTrial,
    input  wire logic [11:0] level [9],
    output logic             compHigher
);
    logic        noiseQ = 1'h0;
    logic [11:0] vin;
    // Unpowered comparator output wanders every cycle
    always_ff @(posedge sys_clk) noiseQ <= !noiseQ;
    // Only the selected input reaches the hold stage
    always_comb begin
        vin = 12'h000;
        for (int i = 0; i < 9; i++) if (analogSelect[i]) vin = level[i];
    end
    // Trial above the held input
    assign compHigher = converterPowerEnable ? (dacTrial > vin) : noiseQ;
endmodule

// ### dv/acc_conv_ctrl_asserts.sv
`timescale 1ns/10ps
module acc_conv_ctrl_asserts (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [8:0]  analogSelect,
    input wire logic        converterPowerEnable,
    input wire logic        conversionIrq,
    input wire logic        brakeIrq,
    input wire logic        faultBrake
);
    logic wrAcc;
    assign wrAcc = psel && penable && pwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Bus answer timing and refusal
    answer_time_a: assert property (psel && !penable |=> pready) else $error("no answer");
    answer_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray answer");
    refusal_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("refusal");
    // Analog routing
    select_onehot_a: assert property ($onehot0(analogSelect)) else $error("select");
    power_gate_a: assert property (!converterPowerEnable |-> !analogSelect) else $error("unpowered");
    // Brake pulse and sticky flags
    brake_pulse_a: assert property (faultBrake |=> !faultBrake) else $error("brake");
    brake_sticky_a: assert property ($fell(brakeIrq) |-> $past(wrAcc) || $past(wrAcc, 2)) else $error("bflag");
    done_sticky_a: assert property ($fell(conversionIrq) |-> $past(wrAcc) || $past(wrAcc, 2)) else $error("dflag");
    cover property (faultBrake);
    cover property ($rose(conversionIrq));
    cover property (pslverr);
endmodule
bind acc_conv_ctrl acc_conv_ctrl_asserts chk (.sys_clk, .reset_n, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .analogSelect, .converterPowerEnable, .conversionIrq, .brakeIrq, .faultBrake);

// ### dv/tb.sv
`timescale 1ns/10ps
`include "acc_defs.svh"
module tb;
    logic        sys_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pinA = 1'h0;
    logic        fPin = 1'h0, pinB = 1'h0, pready, pslverr, cHi, cIrq, bIrq, fBrk, pwr;
    logic [11:0] paddr = 12'h000, dac, v, level [9] = '{default: 12'h000};
    logic [31:0] pwdata = 32'h0000_0000, prdata, expQ [$];
    logic [8:0]  aSel;
    logic [2:0]  pwm = 3'h0;
    int          numErrors = 0, nChecks = 0, cycles = 0, brakes = 0;
    always #2.5 sys_clk = !sys_clk;
    acc_conv_ctrl uut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .analogSelect(aSel), .converterPowerEnable(pwr), .dacTrial(dac), .compHigher(cHi), .pwmChannel(pwm),
        .pwmPeriodCenter(3'h0), .pwmPeriodEnd(3'h0), .triggerPinA(pinA), .triggerPinB(pinB), .faultInputPin(fPin),
        .conversionIrq(cIrq), .brakeIrq(bIrq), .faultBrake(fBrk));
    acc_front_model front (.sys_clk, .analogSelect(aSel), .converterPowerEnable(pwr), .dacTrial(dac), .level,
        .compHigher(cHi));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic endOfTest;
        $display("checks %0d mismatches %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One APB transfer; a read notes its expected data
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        if (!wr) expQ.push_back(d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic waitIrq(input logic want);
        for (int n = 0; n < 600 && cIrq !== want; n++) @(posedge sys_clk);
        check("conversionIrq", cIrq, want);
    endtask
    // Read answers against notes, brake pulses, hang limit
    always @(posedge sys_clk) begin
        if (pready === 1'h1 && pwrite === 1'h0) check("prdata", prdata, expQ.pop_front());
        if (pready === 1'h1) check("pslverr", pslverr, paddr > `ACC_ADDR_BRAKE);
        if (fBrk === 1'h1) brakes++;
        if (++cycles > 30000) begin
            numErrors++;
            endOfTest();
        end
    end
    initial begin
        void'($urandom(35156));
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        apb(1'h0, `ACC_ADDR_CTRL0, 32'h0000_0000);
        apb(1'h0, 12'h030, 32'h0000_0000); // unmapped read refused
        apb(1'h1, `ACC_ADDR_CTRL1, 32'h0000_0081);
        apb(1'h1, `ACC_ADDR_BRAKE, 32'h0000_0002);
        // Software start on a random pin, then band-gap; compare inverted, then not
        for (int k = 0; k < 2; k++) begin
            automatic logic [3:0] ch = k ? `ACC_CH_BANDGAP : 4'($urandom_range(7));
            v = 12'($urandom);
            level[ch] = v;
            apb(1'h1, `ACC_ADDR_CMPH, {24'h00_0000, v[11:4]});
            apb(1'h1, `ACC_ADDR_CMPL, {28'h000_0000, v[3:0]});
            apb(1'h1, `ACC_ADDR_CTRL2, k ? 32'h0000_00A0 : 32'h0000_00E0);
            apb(1'h1, `ACC_ADDR_CTRL0, {24'h00_0000, 4'h4, ch});
            apb(1'h0, `ACC_ADDR_CTRL0, {24'h00_0000, 4'h4, ch});
            apb(1'h1, `ACC_ADDR_CTRL0, {24'h00_0000, 4'h4, ch});
            waitIrq(1'h1);
            apb(1'h0, `ACC_ADDR_RESH, {24'h00_0000, v[11:4]});
            apb(1'h0, `ACC_ADDR_RESL, {28'h000_0000, v[3:0]});
            apb(1'h0, `ACC_ADDR_CTRL2, k ? 32'h0000_00B0 : 32'h0000_00E0);
            check("brake events", brakes, k);
            check("brakeIrq", bIrq, k);
            apb(1'h1, `ACC_ADDR_CTRL0, {24'h00_0000, 4'hC, ch});
            apb(1'h0, `ACC_ADDR_CTRL0, {24'h00_0000, 4'h8, ch});
            apb(1'h1, `ACC_ADDR_CTRL0, {28'h000_0000, ch});
            waitIrq(1'h0);
        end
        $display("software conversions finished");
        apb(1'h1, `ACC_ADDR_BRAKE, 32'h0000_0006);
        apb(1'h0, `ACC_ADDR_BRAKE, 32'h0000_0006);
        check("brakeIrq cleared", bIrq, 1'h0);
        fPin <= 1'h1;
        repeat (8) @(posedge sys_clk);
        check("brakeIrq fault", bIrq, 1'h1);
        $display("brake tests finished");
        apb(1'h1, `ACC_ADDR_CTRL2, 32'h0000_0000);
        apb(1'h1, `ACC_ADDR_DELAY, 32'h0000_0003);
        // Each trigger source in turn, rising edge; the last pass uses the swapped pin
        for (int s = 0; s < 5; s++) begin
            automatic logic [1:0] src = 2'(s > 3 ? 3 : s);
            apb(1'h1, `ACC_ADDR_CTRL1, (s == 4) ? 32'h0000_00C7 : 32'h0000_0087);
            apb(1'h1, `ACC_ADDR_CTRL0, {24'h00_0000, 2'h0, src, 4'h5});
            if (s == 3) pinA <= 1'h1;
            else if (s == 4) pinB <= 1'h1;
            else pwm[s] <= 1'h1;
            repeat (10) @(posedge sys_clk);
            apb(1'h0, `ACC_ADDR_CTRL0, {24'h00_0000, 2'h1, src, 4'h5});
            waitIrq(1'h1);
            pinA <= 1'h0;
            pinB <= 1'h0;
            pwm <= 3'h0;
            apb(1'h1, `ACC_ADDR_CTRL0, {24'h00_0000, 2'h0, src, 4'h5});
            waitIrq(1'h0);
        end
        $display("trigger tests finished");
        endOfTest();
    end
endmodule
